// File: hw/epb_port_bank.sv
// Purpose: Parallel port bank of a small 8-bit microcomputer.
// Assumes: Processor access is synchronous to clk; pins sampled on clk.
// Notes: Bidirectional pins appear as in/out/enable triples; enable high drives.
`timescale 1ns/10ps
`default_nettype none
`include "epb_params.svh"

module epb_port_bank
   import epb_pkg::*;
#(
   parameter int WIDTH = `EPB_PORT_W
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Processor side: select a port, write data or direction, read back.
   input wire logic [`EPB_SEL_W-1:0] cpu_sel,
   input wire logic cpu_data_we,
   input wire logic cpu_dir_we,
   input wire logic cpu_dir_rd,
   input wire logic [WIDTH-1:0] cpu_wdata,
   output logic [WIDTH-1:0] cpu_rdata,
   // Bidirectional port pins.
   input wire logic [WIDTH-1:0] first_bidir_port_in,
   output logic [WIDTH-1:0] first_bidir_port_out,
   output logic [WIDTH-1:0] first_bidir_port_oe,
   input wire logic [WIDTH-1:0] second_bidir_port_in,
   output logic [WIDTH-1:0] second_bidir_port_out,
   output logic [WIDTH-1:0] second_bidir_port_oe,
   input wire logic [WIDTH-1:0] third_bidir_port_in,
   output logic [WIDTH-1:0] third_bidir_port_out,
   output logic [WIDTH-1:0] third_bidir_port_oe,
   input wire logic [WIDTH-1:0] fourth_bidir_port_in,
   output logic [WIDTH-1:0] fourth_bidir_port_out,
   output logic [WIDTH-1:0] fourth_bidir_port_oe,
   input wire logic [WIDTH-1:0] fifth_bidir_port_in,
   output logic [WIDTH-1:0] fifth_bidir_port_out,
   output logic [WIDTH-1:0] fifth_bidir_port_oe,
   // Input-only and output-only ports.
   input wire logic [WIDTH-1:0] input_only_port,
   output logic [WIDTH-1:0] output_only_port_out,
   output logic [WIDTH-1:0] output_only_port_oe,
   // Serial unit hookup onto the fourth port.
   input wire logic serial_active,
   input wire logic serial_ready_pin_val,
   input wire logic serial_clk_val,
   input wire logic serial_clk_drive,
   input wire logic serial_tx_pin_val,
   output logic serial_rx_pin,
   output logic serial_clk_in,
   // Timer hookup: shared pin 3 and the dedicated event pin.
   input wire logic timer_pin_shared_en,
   input wire logic timer_event_out_val,
   input wire logic timer_event_drive,
   input wire logic timer_event_pin_in,
   output logic timer_event_pin_out,
   output logic timer_event_pin_oe,
   output logic timer_event_in,
   output logic shared_timer_in,
   // Interrupt pins and their sampled requests.
   input wire logic high_priority_irq_pin,
   output logic high_priority_irq_req,
   output logic low_priority_irq_pin
);

   // Pin convention: every bidirectional pin appears as an input sample, an output
   // level and an output enable; enable high means this block drives the pin.
   // The board owns the resolution, so a released pin shows its pull level.
   // Select codes 0 to 4 reach the five bidirectional ports, 5 the input-only
   // port, 6 the output-only latch; code 7 reads zero and takes no writes.
   // Every pin level seen by software passes one sampling flop, so a read
   // returns the pin as it stood at the edge before the select was taken.
   // That costs one cycle of latency but keeps the read mux free of board
   // timing; software here never needs a same-cycle view of a pin.
   // The data latches come out of reset at all ones, so a pin of the four sink-only ports
   // that software turns to output before writing its latch stays released rather than
   // pulling the line low by surprise; a fifth-port pin drives high at once.
   // The data latch itself is not read back through the mux: data reads of a
   // bidirectional port always return the pin, as open-drain logic needs.
   // A limitation: a pin driven low by this block also reads back low, so
   // software cannot tell its own drive from a board driver on the line.
   // All state below moves only on an edge with clk_en high; with clk_en low
   // every latch, enable and sample holds its value.
   // Per-port bundles indexed by port number.
   logic [WIDTH-1:0] pin_in [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] pin_out [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] pin_oe [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] dir_q [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] pin_q [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] alt_en [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] alt_out [`EPB_NUM_BIDIR];
   logic [WIDTH-1:0] alt_dir [`EPB_NUM_BIDIR];
   // Output-only latch and registered pin stages.
   logic [WIDTH-1:0] oport_reg;
   logic [WIDTH-1:0] oport_oe_reg;
   logic [WIDTH-1:0] iport_reg;
   logic [WIDTH-1:0] rdata_reg;
   logic [WIDTH-1:0] rdata_next;
   logic tev_oe_reg;
   logic tev_in_reg;
   logic hirq_reg;
   // Shared-function enables and values for the fourth port.
   logic [WIDTH-1:0] p4_alt_en;
   logic [WIDTH-1:0] p4_alt_out;
   logic [WIDTH-1:0] p4_alt_dir;
   // Decoded write strobes.
   logic oport_we;

   // Elaboration check: the shared pin map on the fourth port is fixed to eight
   // pins, so any other width is refused before any logic is built.
   if (WIDTH != `EPB_PORT_W)
   begin : g_bad_width
      $error("epb_port_bank: shared pin map needs WIDTH of 8.");
   end

   // Shared functions on the fourth port override the latch and direction bit
   // of the pins they own while enabled. The serial unit owns the upper nibble
   // as one group; the timer owns pin 3 alone. Pin 2 is never taken over: the
   // low-priority interrupt only reads it, so software must keep its direction
   // bit at zero for the interrupt to see the board level.
   // The ready pin is active low; its value comes from the serial unit as is.
   // Serial owns pins 7..4 while active; pin 4 is its receive input.
   assign p4_alt_en = {serial_active, serial_active, serial_active, serial_active,
                       timer_pin_shared_en, 3'h0};
   assign p4_alt_dir = {1'b1, serial_clk_drive, 1'b1, 1'b0,
                        timer_event_drive, 3'h0};
   assign p4_alt_out = {serial_ready_pin_val, serial_clk_val, serial_tx_pin_val,
                        1'b1, timer_event_out_val, 3'h0};
   // The output-only latch is the only write target outside the generate loop.
   // Writes to code 5 and 7 decode to nothing and are dropped without notice.
   assign oport_we = cpu_data_we && (cpu_sel == `EPB_SEL_OUTPUT_ONLY);

   // Five identical bidirectional ports; only the fifth sources current.
   genvar p;
   generate
      for (p = 0; p < `EPB_NUM_BIDIR; p++)
      begin : g_port
         // Write strobes for this port; the select code equals the port index.
         logic port_hit;
         logic data_hit;
         logic dir_hit;
         assign port_hit = (cpu_sel == (`EPB_SEL_W)'(p));
         assign data_hit = cpu_data_we && port_hit;
         assign dir_hit = cpu_dir_we && port_hit;
         // Only the fourth port has shared functions; the others see zeros.
         assign alt_en[p] = (p == 3) ? p4_alt_en : '0;
         assign alt_out[p] = (p == 3) ? p4_alt_out : '0;
         assign alt_dir[p] = (p == 3) ? p4_alt_dir : '0;
         epb_bidir_port #(
            .WIDTH(WIDTH),
            .DRIVE((p == 4) ? EPB_SOURCE_ONLY : EPB_SINK_ONLY)
         ) u_port (
            .clk(clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .data_we(data_hit),
            .dir_we(dir_hit),
            .wdata(cpu_wdata),
            .alt_en(alt_en[p]),
            .alt_out(alt_out[p]),
            .alt_dir(alt_dir[p]),
            .pin_in(pin_in[p]),
            .pin_out(pin_out[p]),
            .pin_oe(pin_oe[p]),
            .dir_q(dir_q[p]),
            .data_q(),
            .pin_q(pin_q[p])
         );
      end
   endgenerate

   // Flatten the per-port bundles onto the named pins. The outputs pass
   // straight from the port flops, so nothing here adds a logic level
   // between a flip-flop and a pin.
   assign pin_in[0] = first_bidir_port_in;
   assign pin_in[1] = second_bidir_port_in;
   assign pin_in[2] = third_bidir_port_in;
   assign pin_in[3] = fourth_bidir_port_in;
   assign pin_in[4] = fifth_bidir_port_in;

   // Registered drive levels and enables of the five ports.
   assign first_bidir_port_out = pin_out[0];
   assign first_bidir_port_oe = pin_oe[0];
   assign second_bidir_port_out = pin_out[1];
   assign second_bidir_port_oe = pin_oe[1];
   assign third_bidir_port_out = pin_out[2];
   assign third_bidir_port_oe = pin_oe[2];
   assign fourth_bidir_port_out = pin_out[3];
   assign fourth_bidir_port_oe = pin_oe[3];
   assign fifth_bidir_port_out = pin_out[4];
   assign fifth_bidir_port_oe = pin_oe[4];

   // The read result is registered, so cpu_rdata answers one edge after the
   // select. The direction flag is only looked at for codes 0 to 4; on the
   // other codes it is ignored rather than refused, which keeps the decode
   // to one level of selection.
   // Read mux: bidir ports return the sampled pins, or direction on request.
   always_comb
   begin
      rdata_next = '0;
      case (cpu_sel)
         3'h0, 3'h1, 3'h2, 3'h3, 3'h4:
         begin
            // Bidirectional ports: pins as sampled, or the direction latch.
            rdata_next = cpu_dir_rd ? dir_q[cpu_sel] : pin_q[cpu_sel];
         end
         `EPB_SEL_INPUT_ONLY:
         begin
            // Input-only port: the sample taken at the previous edge.
            rdata_next = iport_reg;
         end
         `EPB_SEL_OUTPUT_ONLY:
         begin
            // Output-only port: the latch, since its pins only sink.
            rdata_next = oport_reg;
         end
         default:
         begin
            // Unused code 7 reads as zero.
            rdata_next = '0;
         end
      endcase
   end

   // The enable is built from the latch, not from the write data, so the pin
   // moves one edge after the latch; this keeps all pin enables registered
   // and glitch free at the cost of one more cycle of latency.
   // Output-only port: latch always drives, but only by sinking low.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         oport_reg <= `EPB_DATA_RST;
         oport_oe_reg <= '0;
      end
      else if (clk_en)
      begin
         // The latch only changes on a decoded write.
         if (oport_we)
         begin
            oport_reg <= cpu_wdata;
         end
         // A zero latch bit pulls its pin low; a one releases it.
         oport_oe_reg <= ~oport_reg;
      end
   end

   // The high-priority pin is active low on the board; the request flop holds
   // the inverted level so that a high request always means pending.
   // The dedicated timer pin is open drain too: it only ever pulls low.
   // Input sampling, read data and the dedicated pins.
   // Reset length is the reset source's duty; any low level here resets at once.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         iport_reg <= '0;
         rdata_reg <= '0;
         tev_oe_reg <= 1'b0;
         tev_in_reg <= 1'b0;
         hirq_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         // The input-only port is never driven; it is only sampled.
         iport_reg <= input_only_port;
         rdata_reg <= rdata_next;
         tev_oe_reg <= timer_event_drive & ~timer_event_out_val;
         tev_in_reg <= timer_event_pin_in;
         // Inverted so that a low pin reads as a pending request.
         hirq_reg <= ~high_priority_irq_pin;
      end
   end

   // Output levels of the sink-only pins are fixed at zero; only the enables
   // carry information. A limitation: no pin of this bank can drive a strong
   // high except the fifth port, so the board must supply the pull-ups.
   assign cpu_rdata = rdata_reg;
   assign output_only_port_out = '0;
   assign output_only_port_oe = oport_oe_reg;
   assign timer_event_pin_out = 1'b0;
   assign timer_event_pin_oe = tev_oe_reg;
   assign timer_event_in = tev_in_reg;
   assign high_priority_irq_req = hirq_reg;
   // Shared inputs come from the registered pin samples of the fourth port.
   assign serial_rx_pin = pin_q[3][`EPB_SER_RX_BIT];
   assign serial_clk_in = pin_q[3][`EPB_SER_CLK_BIT];
   assign shared_timer_in = pin_q[3][`EPB_TMR_BIT];
   assign low_priority_irq_pin = pin_q[3][`EPB_LIRQ_BIT];

endmodule

`default_nettype wire

// File: hw/epb_params.svh
// Purpose: Constants for the eight-bit port bank.
// Assumes: Included by bare name from package and modules.
// Notes: Holds widths, the port count, reset values, pin positions and select codes only.
`ifndef EPB_PARAMS_SVH
`define EPB_PARAMS_SVH

// Width of every port in the bank.
`define EPB_PORT_W 8
// Number of general bidirectional ports.
`define EPB_NUM_BIDIR 5
// Direction reset value: all pins are inputs.
`define EPB_DIR_RST 8'h00
// Data latch reset value.
`define EPB_DATA_RST 8'hFF
// Pin positions of the shared functions on the fourth port.
`define EPB_SER_RDY_BIT 7
`define EPB_SER_CLK_BIT 6
`define EPB_SER_TX_BIT 5
`define EPB_SER_RX_BIT 4
`define EPB_TMR_BIT 3
`define EPB_LIRQ_BIT 2
// Port select codes for processor access.
`define EPB_SEL_W 3
`define EPB_SEL_INPUT_ONLY 3'h5
`define EPB_SEL_OUTPUT_ONLY 3'h6

`endif

// File: hw/epb_pkg.sv
// Purpose: Types for the eight-bit port bank.
// Assumes: epb_params.svh carries the numbers.
// Notes: Only types live here.
`include "epb_params.svh"

package epb_pkg;
   // One port byte.
   typedef logic [`EPB_PORT_W-1:0] epb_byte_t;
   // Output stage style of a bidirectional pin.
   typedef enum logic [1:0]
   {
      EPB_SINK_ONLY = 2'h0,
      EPB_SOURCE_ONLY = 2'h1
   } epb_drive_e;
endpackage

// File: hw/epb_bidir_port.sv
// Purpose: One 8-bit bidirectional port with per-pin direction.
// Assumes: Inputs are synchronous to clk.
// Notes: Output stage is open drain of the style given by a parameter.
`timescale 1ns/10ps
`default_nettype none
`include "epb_params.svh"

module epb_bidir_port
   import epb_pkg::*;
#(
   parameter int WIDTH = `EPB_PORT_W,
   parameter epb_drive_e DRIVE = EPB_SINK_ONLY
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic data_we,
   input wire logic dir_we,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [WIDTH-1:0] alt_en,
   input wire logic [WIDTH-1:0] alt_out,
   input wire logic [WIDTH-1:0] alt_dir,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] dir_q,
   output logic [WIDTH-1:0] data_q,
   output logic [WIDTH-1:0] pin_q
);

   // Direction and data latches, plus the registered pin stage.
   logic [WIDTH-1:0] dir_reg;
   logic [WIDTH-1:0] data_reg;
   logic [WIDTH-1:0] in_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] oe_reg;
   // Effective per-pin drive request, one wire each.
   logic [WIDTH-1:0] eff_dir;
   logic [WIDTH-1:0] eff_val;

   // Elaboration check: the pin stage is built for one to thirty-two pins.
   if (WIDTH < 1 || WIDTH > 32)
   begin : g_bad_width
      $error("epb_bidir_port: WIDTH out of range.");
   end

   // Per pin: pick the shared function or the latch, then the open-drain stage.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_pin
         assign eff_dir[i] = alt_en[i] ? alt_dir[i] : dir_reg[i];
         assign eff_val[i] = alt_en[i] ? alt_out[i] : data_reg[i];
      end
   endgenerate

   // Latches: the data write is kept even while a pin is an input.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dir_reg <= `EPB_DIR_RST;
         data_reg <= `EPB_DATA_RST;
      end
      else if (clk_en)
      begin
         if (dir_we)
         begin
            dir_reg <= wdata;
         end
         if (data_we)
         begin
            data_reg <= wdata;
         end
      end
   end

   // Pin stage: sink-only ports drive low, source-only ports drive high.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         oe_reg <= '0;
         // The level is fixed by the drive style from reset on, so a source
         // port never shows a low level while its enable is still off.
         out_reg <= (DRIVE == EPB_SOURCE_ONLY) ? {WIDTH{1'b1}} : {WIDTH{1'b0}};
         in_reg <= '0;
      end
      else if (clk_en)
      begin
         in_reg <= pin_in;
         if (DRIVE == EPB_SOURCE_ONLY)
         begin
            oe_reg <= eff_dir & eff_val;
            out_reg <= {WIDTH{1'b1}};
         end
         else
         begin
            oe_reg <= eff_dir & ~eff_val;
            out_reg <= '0;
         end
      end
   end

   assign pin_out = out_reg;
   assign pin_oe = oe_reg;
   assign dir_q = dir_reg;
   assign data_q = data_reg;
   assign pin_q = in_reg;

endmodule

`default_nettype wire

// File: testbench/epb_asserts.sv
// Purpose: Concurrent checks on the port bank outputs.
// Assumes: One clock domain; registered outputs move only while clk_en is high.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
`include "epb_params.svh"

module epb_asserts
   import epb_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [`EPB_SEL_W-1:0] cpu_sel,
   input wire logic cpu_data_we,
   input wire logic cpu_dir_we,
   input wire logic cpu_dir_rd,
   input wire logic [WIDTH-1:0] cpu_wdata,
   input wire logic [WIDTH-1:0] cpu_rdata,
   input wire logic [WIDTH-1:0] first_bidir_port_out,
   input wire logic [WIDTH-1:0] second_bidir_port_out,
   input wire logic [WIDTH-1:0] third_bidir_port_out,
   input wire logic [WIDTH-1:0] fourth_bidir_port_in,
   input wire logic [WIDTH-1:0] fifth_bidir_port_out,
   input wire logic [WIDTH-1:0] output_only_port_out,
   input wire logic [WIDTH-1:0] output_only_port_oe,
   input wire logic serial_active,
   input wire logic serial_rx_pin,
   input wire logic timer_event_out_val,
   input wire logic timer_event_drive,
   input wire logic timer_event_pin_oe,
   input wire logic high_priority_irq_pin,
   input wire logic high_priority_irq_req,
   input wire logic low_priority_irq_pin
);
   // All checks share the one clock; reset aborts any check in flight.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Sink-only stages may only ever pull low; the source stage only pulls high.
   sink_low_a: assert property ((first_bidir_port_out | second_bidir_port_out | third_bidir_port_out) == '0)
      else $error("sink port drives a high level");
   src_high_a: assert property (fifth_bidir_port_out == '1)
      else $error("source port drives a low level");
   oo_sink_a: assert property (output_only_port_out == '0)
      else $error("output-only port drives a high level");
   // The output-only enable lands one enabled edge after the write reaches the latch.
   oo_latch_a: assert property ((clk_en && cpu_data_we && cpu_sel == `EPB_SEL_OUTPUT_ONLY)
      ##1 clk_en |=> output_only_port_oe == ~$past(cpu_wdata, 2))
      else $error("output-only enable does not follow latch");
   // A direction write read straight back returns the written byte.
   dir_back_a: assert property ((clk_en && cpu_dir_we && cpu_sel < 3'h5) ##1
      (clk_en && cpu_dir_rd && cpu_sel == $past(cpu_sel)) |=> cpu_rdata == $past(cpu_wdata, 2))
      else $error("direction readback wrong");
   hi_irq_a: assert property (clk_en |=> high_priority_irq_req == !$past(high_priority_irq_pin))
      else $error("high irq request does not track pin");
   lo_irq_a: assert property (clk_en |=> low_priority_irq_pin == $past(fourth_bidir_port_in[2]))
      else $error("low irq sample does not track pin");
   tmr_oe_a: assert property (clk_en |=> timer_event_pin_oe ==
      ($past(timer_event_drive) && !$past(timer_event_out_val)))
      else $error("timer pin enable wrong");
   rx_pin_a: assert property (clk_en && serial_active |=> serial_rx_pin == $past(fourth_bidir_port_in[4]))
      else $error("serial receive sample wrong");

   // Main scenarios that the bench is expected to reach.
   cv_dir: cover property (clk_en && cpu_dir_we && cpu_sel < 3'h5);
   cv_oo: cover property (clk_en && cpu_data_we && cpu_sel == `EPB_SEL_OUTPUT_ONLY);
   cv_ser: cover property (clk_en && serial_active);
endmodule

bind epb_port_bank epb_asserts #(.WIDTH(WIDTH)) u_chk (.clk, .rst_b, .clk_en, .cpu_sel,
   .cpu_data_we, .cpu_dir_we, .cpu_dir_rd, .cpu_wdata, .cpu_rdata, .first_bidir_port_out,
   .second_bidir_port_out, .third_bidir_port_out, .fourth_bidir_port_in, .fifth_bidir_port_out,
   .output_only_port_out, .output_only_port_oe, .serial_active, .serial_rx_pin,
   .timer_event_out_val, .timer_event_drive, .timer_event_pin_oe, .high_priority_irq_pin,
   .high_priority_irq_req, .low_priority_irq_pin);
`default_nettype wire

// File: testbench/epb_board.sv
// Purpose: Board circuitry resolving the five bidirectional ports.
// Assumes: Ports one to four pull up, port five pulls down.
// Notes: The block's drive wins over a board driver on a clash.
`timescale 1ns/10ps
`default_nettype none

module epb_board
#(
   parameter logic [4:0] PULL = 5'h0F
)
(
   input wire logic [4:0][7:0] dut_out,
   input wire logic [4:0][7:0] dut_oe,
   input wire logic [4:0][7:0] ext_val,
   input wire logic [4:0][7:0] ext_oe,
   output logic [4:0][7:0] pin
);
   // A pin nobody drives settles to its pull, never to the last value.
   always_comb
   begin
      for (int p = 0; p < 5; p++)
      begin
         for (int b = 0; b < 8; b++)
         begin
            pin[p][b] = dut_oe[p][b] ? dut_out[p][b] : (ext_oe[p][b] ? ext_val[p][b] : PULL[p]);
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/epb_port_bank_tb.sv
// Purpose: Self-checking bench for the port bank.
// Assumes: Inputs change on the falling edge; board model resolves pins.
// Notes: Integer model of latches and directions predicts every result but the shared-function checks.
`timescale 1ns/10ps
`default_nettype none

module eight_bit_port_bank_tb;
   import epb_pkg::*;
   logic clk, rst_b, clk_en, dwe, dirwe, dirrd, ser, serial_ready_pin, sclk, sclkd, stx, tsh, tval, tdrv;
   logic tpin, hpin, srx, sci, toe, tin, stin, hreq, lirq, tpo;
   logic [2:0] sel;
   logic [7:0] wd, rd, inp, oooe, ooo;
   logic [4:0][7:0] po, pe, ev, eo, pin;
   int n_errors, tests_run, oom;
   int dm[5], lm[5];

   epb_port_bank u_dut (.clk, .rst_b, .clk_en, .cpu_sel(sel), .cpu_data_we(dwe),
      .cpu_dir_we(dirwe), .cpu_dir_rd(dirrd), .cpu_wdata(wd), .cpu_rdata(rd),
      .first_bidir_port_in(pin[0]), .first_bidir_port_out(po[0]), .first_bidir_port_oe(pe[0]),
      .second_bidir_port_in(pin[1]), .second_bidir_port_out(po[1]), .second_bidir_port_oe(pe[1]),
      .third_bidir_port_in(pin[2]), .third_bidir_port_out(po[2]), .third_bidir_port_oe(pe[2]),
      .fourth_bidir_port_in(pin[3]), .fourth_bidir_port_out(po[3]), .fourth_bidir_port_oe(pe[3]),
      .fifth_bidir_port_in(pin[4]), .fifth_bidir_port_out(po[4]), .fifth_bidir_port_oe(pe[4]),
      .input_only_port(inp), .output_only_port_out(ooo), .output_only_port_oe(oooe),
      .serial_active(ser), .serial_ready_pin_val(serial_ready_pin), .serial_clk_val(sclk),
      .serial_clk_drive(sclkd), .serial_tx_pin_val(stx), .serial_rx_pin(srx), .serial_clk_in(sci),
      .timer_pin_shared_en(tsh), .timer_event_out_val(tval), .timer_event_drive(tdrv),
      .timer_event_pin_in(tpin), .timer_event_pin_out(tpo), .timer_event_pin_oe(toe),
      .timer_event_in(tin), .shared_timer_in(stin), .high_priority_irq_pin(hpin),
      .high_priority_irq_req(hreq), .low_priority_irq_pin(lirq));
   epb_board u_board (.dut_out(po), .dut_oe(pe), .ext_val(ev), .ext_oe(eo), .pin(pin));

   // Free-running 125 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counts every compare and reports a mismatch at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Expected enables: sink ports drive on a zero latch bit, port five on a one.
   function automatic logic [7:0] exp_oe(input int p);
      return (p == 4) ? 8'(dm[p] & lm[p]) : 8'(dm[p] & ~lm[p]);
   endfunction

   // Expected pin level from model drive, board drive and pull.
   function automatic logic [7:0] exp_pin(input int p);
      if (p == 4)
         return exp_oe(p) | (eo[p] & ev[p]);
      return ~exp_oe(p) & (~eo[p] | ev[p]);
   endfunction

   task automatic rd_chk(input int s, input logic r, input logic [7:0] x);
      sel = 3'(s);
      dirrd = r;
      @(negedge clk);
      check(rd, x);
   endtask

   // Every port enable and every readback select against the model.
   task automatic check_all;
      for (int p = 0; p < 5; p++) check(pe[p], exp_oe(p));
      check(oooe, 8'(~oom));
      check(ooo, 8'h00);
      check(8'(tpo), 8'h00);
      rd_chk(6, 1'b0, 8'(oom));
      for (int s = 0; s < 5; s++) rd_chk(s, 1'b1, 8'(dm[s]));
      for (int s = 0; s < 5; s++) rd_chk(s, 1'b0, exp_pin(s));
      rd_chk(5, 1'b0, inp);
      rd_chk(7, 1'b0, 8'h00);
      dirrd = 1'b0;
   endtask

   // The board needs far longer than this; the block resets at once on a low level.
   task automatic do_reset;
      rst_b = 1'b0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      foreach (dm[p]) dm[p] = 0;
      foreach (lm[p]) lm[p] = 255;
      oom = 255;
   endtask

   // Hang guard: ends the run as a failure.
   initial
   begin
      repeat (50000) @(posedge clk);
      n_errors++;
      print_verdict();
   end

   initial
   begin
      {rst_b, clk_en, dwe, dirwe, dirrd, ser, serial_ready_pin, sclk, sclkd, stx, tsh, tval, tdrv} = '0;
      {tpin, hpin, sel, wd, inp, ev, eo} = '0;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(32'h9900350D));
      do_reset();
      clk_en = 1'b1;
      check_all();
      // Random writes, refused selects and frozen cycles, then full compare.
      for (int i = 0; i < 60; i++)
      begin
         sel = 3'($urandom);
         wd = 8'($urandom);
         dwe = 1'($urandom);
         dirwe = 1'($urandom);
         clk_en = ($urandom % 4) != 0;
         ev = 40'({$urandom, $urandom});
         eo = 40'({$urandom, $urandom});
         inp = 8'($urandom);
         if (clk_en && dwe && sel == 3'h6)
            oom = wd;
         else if (clk_en && dwe && sel < 3'h5)
            lm[sel] = wd;
         if (clk_en && dirwe && sel < 3'h5)
            dm[sel] = wd;
         @(negedge clk);
         {dwe, dirwe, clk_en} = 3'b001;
         repeat (3) @(negedge clk);
         check_all();
      end
      // Direction write followed at once by its readback.
      for (int p = 0; p < 5; p++)
      begin
         sel = 3'(p);
         wd = 8'($urandom);
         dirwe = 1'b1;
         dm[p] = wd;
         @(negedge clk);
         dirwe = 1'b0;
         rd_chk(p, 1'b1, wd);
      end
      // Shared serial, timer and interrupt functions on the fourth port, plus the dedicated timer event and high-priority interrupt pins.
      ser = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         {serial_ready_pin, sclk, sclkd, stx, tsh, tval, tdrv, tpin, hpin} = 9'($urandom);
         eo[3] = 8'h5C;
         ev[3] = 8'($urandom);
         repeat (3) @(negedge clk);
         check(8'(pe[3][5]), 8'(!stx));
         check(8'(pe[3][7]), 8'(!serial_ready_pin));
         check(8'(srx), 8'(pin[3][4]));
         check(8'(sci), 8'(pin[3][6]));
         check(8'(stin), 8'(pin[3][3]));
         check(8'(lirq), 8'(pin[3][2]));
         check(8'(hreq), 8'(!hpin));
         check(8'(toe), 8'(tdrv & !tval));
         check(8'(tin), 8'(tpin));
      end
      {ser, tsh} = 2'b00;
      // Second reset in mid-run returns every pin to input.
      do_reset();
      check_all();
      print_verdict();
   end
endmodule
`default_nettype wire
